// file: testbench/signal_limit_supervision_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin fail_count++; \
	$display("[ERR] %0t got %0h exp %0h", $time, (g), (e)); end end
module signal_limit_supervision_tb_top
	import ssv_pkg::*;
;
	logic        clk = 0, rst = 1, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
	logic        treq = 0, sreq = 0, run = 0, tick, start, running, s, ar;
	logic        awrdy, wrdy, bval, arrdy, rval, superv, warn, trip, irq;
	logic [1:0]  bresp, rresp, act;
	logic [4:0]  src;
	logic [7:0]  awa = 0, ara = 0;
	logic [15:0] evc, ev;
	logic [31:0] wd = 0, val = 0, rdat, rdata, sig;
	int          fail_count = 0, cmp_count = 0, cyc = 0, trips = 0, t;
	longint      lo, hi, hh, x;

	// Clock, trip pulse counter and hang guard.
	always #20 clk = ~clk;
	always @(negedge clk) trips += trip;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 40000) begin
			fail_count++;
			$display("[ERR] %0t timeout", $time);
			final_report();
		end
	end

	ssv_top dut_u (
		.CLK_SYS_IN(clk), .RESET_IN(rst),
		.S_AXI_AWADDR_IN(awa), .S_AXI_AWVALID_IN(awv), .S_AXI_AWREADY_OUT(awrdy),
		.S_AXI_WDATA_IN(wd), .S_AXI_WSTRB_IN(4'hf), .S_AXI_WVALID_IN(wv),
		.S_AXI_WREADY_OUT(wrdy), .S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bval),
		.S_AXI_BREADY_IN(bry), .S_AXI_ARADDR_IN(ara), .S_AXI_ARVALID_IN(arv),
		.S_AXI_ARREADY_OUT(arrdy), .S_AXI_RDATA_OUT(rdata), .S_AXI_RRESP_OUT(rresp),
		.S_AXI_RVALID_OUT(rval), .S_AXI_RREADY_IN(rry), .SRC_SEL_OUT(src),
		.SIG_VALUE_IN(sig), .TICK_IN(tick), .MOTOR_START_IN(start),
		.MOTOR_RUNNING_IN(running), .SUPERV_OUT(superv), .WARN_OUT(warn),
		.FAULT_TRIP_OUT(trip), .EVENT_CODE_OUT(evc), .IRQ_OUT(irq)
	);
	ssv_drive_model drv_u (
		.clk_in(clk), .tick_req_in(treq), .start_req_in(sreq), .run_req_in(run),
		.val_req_in(val), .tick_out(tick), .start_out(start), .running_out(running),
		.sig_out(sig)
	);

	// Readiness is looked at on the falling edge, so the rising edge decision never races.
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic ta, tw, tb;
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		bry <= 1'b1;
		tb = 0;
		while (!tb) begin
			@(negedge clk);
			ta = awv && awrdy;
			tw = wv && wrdy;
			tb = bval;
			if (tb) `CHK(bresp, er)
			@(posedge clk);
			if (ta) awv <= 1'b0;
			if (tw) wv <= 1'b0;
		end
	endtask

	task automatic rd(input logic [7:0] a, input logic [1:0] er);
		logic ta, tr;
		ara <= a;
		arv <= 1'b1;
		rry <= 1'b1;
		tr = 0;
		while (!tr) begin
			@(negedge clk);
			ta = arv && arrdy;
			tr = rval;
			rdat = rdata;
			if (tr) `CHK(rresp, er)
			@(posedge clk);
			if (ta) arv <= 1'b0;
		end
	endtask

	// One control tick, then enough idle cycles for even a filtered update to land.
	task automatic tk(input longint v);
		treq <= 1'b1;
		val <= v[31:0];
		@(posedge clk);
		treq <= 1'b0;
		repeat (56) @(posedge clk);
	endtask

	// Next {armed, status} of the comparison for mode m, with h the half band.
	function automatic logic [1:0] nxt(input logic [3:0] m, input logic sp, ap,
		input longint xv, lv, hv, h);
		longint ax, al, ah;
		logic   ns, na;
		ax = xv < 0 ? -xv : xv;
		al = lv < 0 ? -lv : lv;
		ah = hv < 0 ? -hv : hv;
		ns = sp;
		na = ap;
		case (m)
			4'h1: if (xv < lv - h) ns = 1; else if (xv > lv + h) ns = 0;
			4'h2: if (xv > hv + h) ns = 1; else if (xv < hv - h) ns = 0;
			4'h3: if (ax < al - h) ns = 1; else if (ax > al + h) ns = 0;
			4'h4: if (ax > ah + h) ns = 1; else if (ax < ah - h) ns = 0;
			4'h5: if (xv > hv + h || xv < lv - h) ns = 1; else if (xv < hv - h && xv > lv + h) ns = 0;
			4'h6: if (ax > ah + h || ax < al - h) ns = 1; else if (ax < ah - h && ax > al + h) ns = 0;
			4'h7: if (xv > hv + h) ns = 1; else if (xv < lv - h) ns = 0;
			4'h8: if (xv > lv + h) {na, ns} = 2'b10; else if (xv < lv - h) {na, ns} = {1'b0, sp | ap};
			4'h9: if (xv < hv - h) {na, ns} = 2'b10; else if (xv > hv + h) {na, ns} = {1'b0, sp | ap};
			default: {na, ns} = 2'b00;
		endcase
		return {na, ns};
	endfunction

	task final_report;
		if (fail_count == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	initial begin
		void'($urandom(83451));
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		// Reset values, saturation and refused accesses.
		`CHK(src, SRC_CURRENT)
		rd(ADDR_CTRL, RESP_OKAY);
		`CHK(rdat, CTRL_RST)
		rd(ADDR_EVENT, RESP_OKAY);
		`CHK(rdat, 32'h0)
		rd(8'h28, RESP_SLVERR);
		wr(ADDR_STATUS, 32'h1, RESP_SLVERR);
		rd(ADDR_FILT, RESP_OKAY);
		`CHK(rdat, 32'h0)
		wr(ADDR_FILT, 32'h9c40, RESP_OKAY);
		rd(ADDR_FILT, RESP_OKAY);
		`CHK(rdat, {16'h0, FILT_MAX})
		wr(ADDR_FILT, 32'h0, RESP_OKAY);
		// Random limits and signal in mode codes 0 to 11, unused codes 10 and 11 (accepted, acting as off) included.
		for (int m = 0; m < 12; m++) begin
			wr(ADDR_CTRL, CTRL_RST, RESP_OKAY);
			lo = longint'($urandom_range(400)) - 200;
			hi = longint'($urandom_range(400)) - 200;
			hh = $urandom_range(60);
			wr(ADDR_LOW, lo[31:0], RESP_OKAY);
			wr(ADDR_HIGH, hi[31:0], RESP_OKAY);
			wr(ADDR_HYST, hh[31:0], RESP_OKAY);
			wr(ADDR_CTRL, CTRL_RST | 32'(m), RESP_OKAY);
			{ar, s} = 2'b00;
			repeat (16) begin
				x = longint'($urandom_range(600)) - 300;
				tk(x);
				{ar, s} = nxt(4'(m), s, ar, x, lo, hi, hh >> 1);
				`CHK(superv, s)
			end
		end
		// Each reaction on the band edges of the upper limit; the mask is clear only for the first pass, with no reaction.
		wr(ADDR_CTRL, CTRL_RST, RESP_OKAY);
		wr(ADDR_HIGH, 32'h64, RESP_OKAY);
		wr(ADDR_HYST, 32'ha, RESP_OKAY);
		wr(ADDR_IRQ_STAT, 32'h7, RESP_OKAY);
		ev = 16'h0;
		for (int k = 0; k < 5; k++) begin
			act = k > 3 ? 2'h3 : 2'(k);
			run <= (k == 4);
			wr(ADDR_IRQ_MASK, 32'(k != 0), RESP_OKAY);
			wr(ADDR_CTRL, CTRL_RST | 32'({act, MODE_HIGH}), RESP_OKAY);
			t = trips;
			tk(94);
			tk(105);
			`CHK(superv, 1'b0)
			tk(106);
			`CHK(superv, 1'b1)
			`CHK(trips - t, int'(act == ACT_FAULT || k == 4))
			if (act == ACT_WARN) ev = EVT_WARN;
			if (act == ACT_FAULT || k == 4) ev = EVT_FAULT;
			`CHK(warn, act == ACT_WARN)
			`CHK(evc, ev)
			`CHK(irq, k != 0)
			rd(ADDR_STATUS, RESP_OKAY);
			`CHK(rdat[0], 1'b1)
			wr(ADDR_IRQ_STAT, 32'h7, RESP_OKAY);
			`CHK(irq, 1'b0)
			tk(95);
			`CHK(superv, 1'b1)
			tk(94);
			`CHK(superv, 1'b0)
			`CHK(warn, 1'b0)
		end
		// Falling edge status set, cleared by a start command, not set again unarmed.
		wr(ADDR_CTRL, CTRL_RST, RESP_OKAY);
		wr(ADDR_LOW, 32'h0, RESP_OKAY);
		wr(ADDR_CTRL, CTRL_RST | 32'(MODE_FALLING), RESP_OKAY);
		tk(20);
		tk(-20);
		`CHK(superv, 1'b1)
		sreq <= 1'b1;
		@(posedge clk);
		sreq <= 1'b0;
		repeat (3) @(posedge clk);
		`CHK(superv, 1'b0)
		tk(-20);
		`CHK(superv, 1'b0)
		// One filter step with a time constant of one tick halves the distance.
		wr(ADDR_CTRL, CTRL_RST | 32'(MODE_HIGH), RESP_OKAY);
		tk(1000);
		wr(ADDR_FILT, 32'h1, RESP_OKAY);
		tk(0);
		rd(ADDR_VALUE, RESP_OKAY);
		`CHK(rdat, 32'h1f4)
		final_report();
	end
endmodule
`default_nettype wire

// file: testbench/ssv_checker.sv
`timescale 1ns/100ps
`default_nettype none
module ssv_checker
	import ssv_pkg::*;
(
	// Clock and reset.
	input wire logic        CLK_SYS_IN,
	input wire logic        RESET_IN,
	// Register writes.
	input wire logic [7:0]  S_AXI_AWADDR_IN,
	input wire logic        S_AXI_AWVALID_IN,
	input wire logic        S_AXI_AWREADY_OUT,
	input wire logic [31:0] S_AXI_WDATA_IN,
	input wire logic        S_AXI_WVALID_IN,
	input wire logic        S_AXI_WREADY_OUT,
	// Drive side and results.
	input wire logic        TICK_IN,
	input wire logic        MOTOR_START_IN,
	input wire logic        SUPERV_OUT,
	input wire logic        WARN_OUT,
	input wire logic        FAULT_TRIP_OUT,
	input wire logic [15:0] EVENT_CODE_OUT
);
	logic       wr_hs;
	logic       en;
	logic [3:0] mode_r;
	logic [1:0] act_r;

	// Shadow of mode and action; only same-edge address and data writes are seen.
	assign wr_hs = S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT && S_AXI_WVALID_IN && S_AXI_WREADY_OUT;
	assign en = (mode_r != MODE_OFF) && (mode_r <= MODE_RISING);
	always_ff @(posedge CLK_SYS_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			mode_r <= MODE_OFF;
			act_r  <= ACT_NONE;
		end else if (wr_hs && S_AXI_AWADDR_IN == ADDR_CTRL) begin
			mode_r <= S_AXI_WDATA_IN[3:0];
			act_r  <= S_AXI_WDATA_IN[5:4];
		end
	end

	default clocking @(posedge CLK_SYS_IN); endclocking
	default disable iff (RESET_IN);

	mode_off_a: assert property (!en && !$past(en) && !$past(en, 2) |-> !SUPERV_OUT)
		else $error("status set while disabled");
	start_clear_a: assert property (MOTOR_START_IN && mode_r[3] && en |=> !SUPERV_OUT)
		else $error("start did not clear status");
	// A status change needs a compare, a start or a settings write as its cause.
	status_cause_a: assert property ($changed(SUPERV_OUT) |-> $past(TICK_IN, 2)
		|| $past(TICK_IN, 51) || $past(MOTOR_START_IN) || $past(wr_hs) || $past(wr_hs, 3))
		else $error("status changed without cause");
	warn_set_a: assert property (SUPERV_OUT && en && act_r == ACT_WARN |=> WARN_OUT)
		else $error("warning missing");
	warn_clear_a: assert property (!SUPERV_OUT |=> !WARN_OUT)
		else $error("warning without status");
	fault_trip_a: assert property ($rose(SUPERV_OUT) && act_r == ACT_FAULT |-> FAULT_TRIP_OUT)
		else $error("fault trip missing");
	trip_cause_a: assert property (FAULT_TRIP_OUT |-> $rose(SUPERV_OUT) && act_r[1])
		else $error("trip without cause");
	trip_once_a: assert property (FAULT_TRIP_OUT |=> !FAULT_TRIP_OUT)
		else $error("trip longer than one cycle");
	trip_code_a: assert property (FAULT_TRIP_OUT |-> EVENT_CODE_OUT == EVT_FAULT)
		else $error("wrong fault code");
	warn_code_a: assert property ($rose(WARN_OUT) |-> EVENT_CODE_OUT == EVT_WARN)
		else $error("wrong warning code");

	// Main scenarios reached.
	cover property ($rose(SUPERV_OUT));
	cover property (FAULT_TRIP_OUT);
	cover property (MOTOR_START_IN && SUPERV_OUT);
endmodule
bind ssv_top ssv_checker chk_u (
	.CLK_SYS_IN(CLK_SYS_IN),
	.RESET_IN(RESET_IN),
	.S_AXI_AWADDR_IN(S_AXI_AWADDR_IN),
	.S_AXI_AWVALID_IN(S_AXI_AWVALID_IN),
	.S_AXI_AWREADY_OUT(S_AXI_AWREADY_OUT),
	.S_AXI_WDATA_IN(S_AXI_WDATA_IN),
	.S_AXI_WVALID_IN(S_AXI_WVALID_IN),
	.S_AXI_WREADY_OUT(S_AXI_WREADY_OUT),
	.TICK_IN(TICK_IN),
	.MOTOR_START_IN(MOTOR_START_IN),
	.SUPERV_OUT(SUPERV_OUT),
	.WARN_OUT(WARN_OUT),
	.FAULT_TRIP_OUT(FAULT_TRIP_OUT),
	.EVENT_CODE_OUT(EVENT_CODE_OUT)
);
`default_nettype wire

// file: testbench/ssv_drive_model.sv
`timescale 1ns/100ps
`default_nettype none
module ssv_drive_model (
	// Clock.
	input  wire logic        clk_in,
	// Requests from the bench.
	input  wire logic        tick_req_in,
	input  wire logic        start_req_in,
	input  wire logic        run_req_in,
	input  wire logic [31:0] val_req_in,
	// Drive side of the channel.
	output logic             tick_out,
	output logic             start_out,
	output logic             running_out,
	output logic [31:0]      sig_out
);
	// Quiet drive at time zero, before the first control tick.
	initial begin
		tick_out = 1'b0;
		start_out = 1'b0;
		running_out = 1'b0;
		sig_out = 32'h0;
	end

	// One tick per request; the signal is held steady while the channel samples it.
	always @(posedge clk_in) begin
		tick_out <= tick_req_in;
		start_out <= start_req_in;
		running_out <= run_req_in;
		sig_out <= val_req_in;
	end
endmodule
`default_nettype wire

// file: verilog/ssv_pkg.sv
`default_nettype none
package ssv_pkg;

	// Register byte offsets on the AXI4-Lite slave.
	localparam logic [7:0] ADDR_CTRL     = 8'h00;
	localparam logic [7:0] ADDR_FILT     = 8'h04;
	localparam logic [7:0] ADDR_LOW      = 8'h08;
	localparam logic [7:0] ADDR_HIGH     = 8'h0c;
	localparam logic [7:0] ADDR_HYST     = 8'h10;
	localparam logic [7:0] ADDR_STATUS   = 8'h14;
	localparam logic [7:0] ADDR_VALUE    = 8'h18;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h1c;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h20;
	localparam logic [7:0] ADDR_EVENT    = 8'h24;

	// Control register field positions.
	localparam int MODE_LSB   = 0;
	localparam int ACTION_LSB = 4;
	localparam int SOURCE_LSB = 8;

	// Function modes.
	localparam logic [3:0] MODE_OFF      = 4'h0;
	localparam logic [3:0] MODE_LOW      = 4'h1;
	localparam logic [3:0] MODE_HIGH     = 4'h2;
	localparam logic [3:0] MODE_ABS_LOW  = 4'h3;
	localparam logic [3:0] MODE_ABS_HIGH = 4'h4;
	localparam logic [3:0] MODE_BOTH     = 4'h5;
	localparam logic [3:0] MODE_ABS_BOTH = 4'h6;
	localparam logic [3:0] MODE_HYST     = 4'h7;
	localparam logic [3:0] MODE_FALLING  = 4'h8;
	localparam logic [3:0] MODE_RISING   = 4'h9;

	// Reactions and the event codes they report.
	localparam logic [1:0]  ACT_NONE      = 2'h0;
	localparam logic [1:0]  ACT_WARN      = 2'h1;
	localparam logic [1:0]  ACT_FAULT     = 2'h2;
	localparam logic [1:0]  ACT_FAULT_RUN = 2'h3;
	localparam logic [15:0] EVT_WARN      = 16'ha8b0;
	localparam logic [15:0] EVT_FAULT     = 16'h80b0;

	// Source code of motor current; the value is arbitrary.
	localparam logic [4:0]  SRC_CURRENT = 5'h01;
	localparam logic [31:0] CTRL_RST    = 32'h0000_0100;

	// Filter time in ms: 1000 counts per second, up to 30 s, default off.
	localparam logic [15:0] FILT_MAX     = 16'h7530;
	localparam logic [15:0] FILT_RST     = 16'h0000;
	localparam logic [16:0] FILT_TICK_MS = 17'h00001;
	localparam int          FRAC_BITS    = 16;
	localparam logic [5:0]  DIV_LAST     = 6'h2f;

	// Interrupt status bit positions.
	localparam int IRQ_ASSERT = 0;
	localparam int IRQ_WARN   = 1;
	localparam int IRQ_FAULT  = 2;
	localparam int IRQ_W      = 3;

	// AXI response codes.
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Filter and compare sequencer states.
	typedef enum logic [1:0] {
		SSV_IDLE  = 2'b00,
		SSV_DIV   = 2'b01,
		SSV_APPLY = 2'b10,
		SSV_CMP   = 2'b11
	} ssv_state_e;

endpackage
`default_nettype wire

// file: verilog/ssv_top.sv
// Implementation choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module ssv_top
	import ssv_pkg::*;
(
	// Clock and reset.
	input  wire  logic        CLK_SYS_IN,
	input  wire  logic        RESET_IN,
	// AXI4-Lite write channels.
	input  wire  logic [7:0]  S_AXI_AWADDR_IN,
	input  wire  logic        S_AXI_AWVALID_IN,
	output logic              S_AXI_AWREADY_OUT,
	input  wire  logic [31:0] S_AXI_WDATA_IN,
	input  wire  logic [3:0]  S_AXI_WSTRB_IN,
	input  wire  logic        S_AXI_WVALID_IN,
	output logic              S_AXI_WREADY_OUT,
	output logic [1:0]        S_AXI_BRESP_OUT,
	output logic              S_AXI_BVALID_OUT,
	input  wire  logic        S_AXI_BREADY_IN,
	// AXI4-Lite read channels.
	input  wire  logic [7:0]  S_AXI_ARADDR_IN,
	input  wire  logic        S_AXI_ARVALID_IN,
	output logic              S_AXI_ARREADY_OUT,
	output logic [31:0]       S_AXI_RDATA_OUT,
	output logic [1:0]        S_AXI_RRESP_OUT,
	output logic              S_AXI_RVALID_OUT,
	input  wire  logic        S_AXI_RREADY_IN,
	// Monitored signal and drive state.
	output logic [4:0]        SRC_SEL_OUT,
	input  wire  logic [31:0] SIG_VALUE_IN,
	input  wire  logic        TICK_IN,
	input  wire  logic        MOTOR_START_IN,
	input  wire  logic        MOTOR_RUNNING_IN,
	// Supervision results.
	output logic              SUPERV_OUT,
	output logic              WARN_OUT,
	output logic              FAULT_TRIP_OUT,
	output logic [15:0]       EVENT_CODE_OUT,
	output logic              IRQ_OUT
);

	// Sign-extends a 32-bit value so that limit arithmetic cannot overflow.
	function automatic logic signed [33:0] ext34(input logic signed [31:0] a);
		return {{2{a[31]}}, a};
	endfunction

	// Magnitude in the same widened form.
	function automatic logic signed [33:0] mag34(input logic signed [31:0] a);
		return a[31] ? -ext34(a) : ext34(a);
	endfunction

	// Applies AXI byte strobes to a stored word.
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] strb);
		logic [31:0] res;
		for (int i = 0; i < 4; i++) begin
			res[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
		end
		return res;
	endfunction

	// Configuration registers.
	logic [31:0]        ctrl_r;
	logic [15:0]        filt_r;
	logic signed [31:0] low_r, high_r;
	logic [31:0]        hyst_r;
	logic [IRQ_W-1:0]   irq_stat_r, irq_mask_r;
	logic [3:0]         mode;
	logic [1:0]         action;
	logic               enabled, edge_mode;
	// Bus state.
	logic               aw_held_r, w_held_r, bvalid_r, rvalid_r;
	logic               do_write, wr_ok, rd_ok;
	logic [7:0]         aw_addr_r;
	logic [31:0]        w_data_r, rdata_r, wr_val, rd_val;
	logic [3:0]         w_strb_r;
	logic [1:0]         bresp_r, rresp_r;
	// Filter, compare and reaction state.
	ssv_state_e         state_r;
	logic signed [47:0] y_r;
	logic [47:0]        num_r, quo_r;
	logic [15:0]        rem_r, event_r;
	logic [5:0]         cnt_r;
	logic signed [48:0] diff;
	logic [16:0]        den, rem_sh;
	logic               neg_r, sup_r, armed_r, sup_cmp, armed_cmp;
	logic               start_clr, sup_rise, warn_evt, fault_evt, warn_r, fault_r;

	assign mode      = ctrl_r[MODE_LSB +: 4];
	assign action    = ctrl_r[ACTION_LSB +: 2];
	assign enabled   = (mode != MODE_OFF) && (mode <= MODE_RISING);
	assign edge_mode = (mode == MODE_FALLING) || (mode == MODE_RISING);

	// Both write channels may arrive in either order; each is held until the pair completes.
	assign S_AXI_AWREADY_OUT = !aw_held_r && !bvalid_r;
	assign S_AXI_WREADY_OUT  = !w_held_r && !bvalid_r;
	assign S_AXI_BVALID_OUT  = bvalid_r;
	assign S_AXI_BRESP_OUT   = bresp_r;
	assign do_write          = aw_held_r && w_held_r && !bvalid_r;
	assign wr_val            = merge(32'h0000_0000, w_data_r, w_strb_r);
	assign wr_ok             = (aw_addr_r == ADDR_CTRL) || (aw_addr_r == ADDR_FILT) ||
		(aw_addr_r == ADDR_LOW) || (aw_addr_r == ADDR_HIGH) || (aw_addr_r == ADDR_HYST) ||
		(aw_addr_r == ADDR_IRQ_STAT) || (aw_addr_r == ADDR_IRQ_MASK);

	// Write address and data capture, then one response per pair.
	always_ff @(posedge CLK_SYS_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			aw_held_r <= 1'b0;
			w_held_r  <= 1'b0;
			aw_addr_r <= 8'h00;
			w_data_r  <= 32'h0000_0000;
			w_strb_r  <= 4'h0;
			bvalid_r  <= 1'b0;
			bresp_r   <= RESP_OKAY;
		end else begin
			if (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT) begin
				aw_held_r <= 1'b1;
				aw_addr_r <= S_AXI_AWADDR_IN;
			end
			if (S_AXI_WVALID_IN && S_AXI_WREADY_OUT) begin
				w_held_r <= 1'b1;
				w_data_r <= S_AXI_WDATA_IN;
				w_strb_r <= S_AXI_WSTRB_IN;
			end
			if (do_write) begin
				aw_held_r <= 1'b0;
				w_held_r  <= 1'b0;
				bvalid_r  <= 1'b1;
				bresp_r   <= wr_ok ? RESP_OKAY : RESP_SLVERR;
			end else if (bvalid_r && S_AXI_BREADY_IN) begin
				bvalid_r <= 1'b0;
			end
		end
	end

	// Software-written configuration; the filter time saturates at 30 s.
	always_ff @(posedge CLK_SYS_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			ctrl_r     <= CTRL_RST;
			filt_r     <= FILT_RST;
			low_r      <= 32'h0000_0000;
			high_r     <= 32'h0000_0000;
			hyst_r     <= 32'h0000_0000;
			irq_mask_r <= 3'h0;
		end else if (do_write) begin
			unique case (aw_addr_r)
				ADDR_CTRL: ctrl_r <= merge(ctrl_r, w_data_r, w_strb_r) & 32'h0000_1f3f;
				ADDR_FILT: filt_r <= (wr_val[31:16] != 16'h0000 ||
					merge({16'h0000, filt_r}, w_data_r, w_strb_r) > {16'h0000, FILT_MAX}) ?
					FILT_MAX : 16'(merge({16'h0000, filt_r}, w_data_r, w_strb_r));
				ADDR_LOW:      low_r      <= merge(low_r, w_data_r, w_strb_r);
				ADDR_HIGH:     high_r     <= merge(high_r, w_data_r, w_strb_r);
				ADDR_HYST:     hyst_r     <= merge(hyst_r, w_data_r, w_strb_r);
				ADDR_IRQ_MASK: irq_mask_r <= wr_val[IRQ_W-1:0];
				default: ;
			endcase
		end
	end

	// Read decode; unmapped addresses answer zero with SLVERR.
	always_comb begin
		rd_ok  = 1'b1;
		rd_val = 32'h0000_0000;
		unique case (S_AXI_ARADDR_IN)
			ADDR_CTRL:     rd_val = ctrl_r;
			ADDR_FILT:     rd_val = {16'h0000, filt_r};
			ADDR_LOW:      rd_val = low_r;
			ADDR_HIGH:     rd_val = high_r;
			ADDR_HYST:     rd_val = hyst_r;
			ADDR_STATUS:   rd_val = {28'h0000000, armed_r, state_r != SSV_IDLE, warn_r, sup_r};
			ADDR_VALUE:    rd_val = y_r[47:FRAC_BITS];
			ADDR_IRQ_STAT: rd_val = {29'h00000000, irq_stat_r};
			ADDR_IRQ_MASK: rd_val = {29'h00000000, irq_mask_r};
			ADDR_EVENT:    rd_val = {16'h0000, event_r};
			default:       rd_ok  = 1'b0;
		endcase
	end

	assign S_AXI_ARREADY_OUT = !rvalid_r;
	assign S_AXI_RVALID_OUT  = rvalid_r;
	assign S_AXI_RDATA_OUT   = rdata_r;
	assign S_AXI_RRESP_OUT   = rresp_r;

	// Read data is registered, so the answer follows the address by one cycle.
	always_ff @(posedge CLK_SYS_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			rvalid_r <= 1'b0;
			rdata_r  <= 32'h0000_0000;
			rresp_r  <= RESP_OKAY;
		end else if (S_AXI_ARVALID_IN && !rvalid_r) begin
			rvalid_r <= 1'b1;
			rdata_r  <= rd_val;
			rresp_r  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid_r && S_AXI_RREADY_IN) begin
			rvalid_r <= 1'b0;
		end
	end

	assign SRC_SEL_OUT = ctrl_r[SOURCE_LSB +: 5];
	// Filter step y += (x - y) / (T + 1), with 16 fraction bits so small steps are not lost.
	assign diff   = {SIG_VALUE_IN[31], SIG_VALUE_IN, 16'h0000} - {y_r[47], y_r};
	assign den    = {1'b0, filt_r} + FILT_TICK_MS;
	assign rem_sh = {rem_r, num_r[47]};

	// Sequencer: a tick starts a filter update, ticks arriving while busy are dropped.
	always_ff @(posedge CLK_SYS_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			state_r <= SSV_IDLE;
			y_r     <= 48'h0000_0000_0000;
			num_r   <= 48'h0000_0000_0000;
			quo_r   <= 48'h0000_0000_0000;
			rem_r   <= 16'h0000;
			neg_r   <= 1'b0;
			cnt_r   <= 6'h00;
		end else begin
			unique case (state_r)
				SSV_IDLE: begin
					if (TICK_IN && filt_r == FILT_RST) begin
						y_r     <= {SIG_VALUE_IN, 16'h0000};
						state_r <= SSV_CMP;
					end else if (TICK_IN) begin
						neg_r   <= diff[48];
						num_r   <= diff[48] ? 48'(-diff) : diff[47:0];
						rem_r   <= 16'h0000;
						cnt_r   <= 6'h00;
						state_r <= SSV_DIV;
					end
				end
				SSV_DIV: begin
					num_r <= {num_r[46:0], 1'b0};
					rem_r <= (rem_sh >= den) ? 16'(rem_sh - den) : rem_sh[15:0];
					quo_r <= {quo_r[46:0], rem_sh >= den};
					cnt_r <= cnt_r + 6'h01;
					if (cnt_r == DIV_LAST) begin
						state_r <= SSV_APPLY;
					end
				end
				SSV_APPLY: begin
					y_r     <= neg_r ? y_r - $signed(quo_r) : y_r + $signed(quo_r);
					state_r <= SSV_CMP;
				end
				SSV_CMP: state_r <= SSV_IDLE;
			endcase
		end
	end

	// Threshold compare on the filtered value; absolute modes compare magnitudes.
	always_comb begin
		logic               abs_sel, below_lo, above_lo, below_hi, above_hi;
		logic signed [33:0] sv, lo, hi, half;
		abs_sel   = (mode == MODE_ABS_LOW) || (mode == MODE_ABS_HIGH) ||
			(mode == MODE_ABS_BOTH);
		sv        = abs_sel ? mag34(y_r[47:FRAC_BITS]) : ext34(y_r[47:FRAC_BITS]);
		lo        = abs_sel ? mag34(low_r) : ext34(low_r);
		hi        = abs_sel ? mag34(high_r) : ext34(high_r);
		half      = {3'b000, hyst_r[31:1]};
		below_lo  = sv < lo - half;
		above_lo  = sv > lo + half;
		below_hi  = sv < hi - half;
		above_hi  = sv > hi + half;
		sup_cmp   = sup_r;
		armed_cmp = armed_r;
		unique case (mode)
			MODE_LOW, MODE_ABS_LOW: begin
				sup_cmp = below_lo ? 1'b1 : (above_lo ? 1'b0 : sup_r);
			end
			MODE_HIGH, MODE_ABS_HIGH: begin
				sup_cmp = above_hi ? 1'b1 : (below_hi ? 1'b0 : sup_r);
			end
			MODE_BOTH, MODE_ABS_BOTH: begin
				if (above_hi || below_lo) begin
					sup_cmp = 1'b1;
				end else if (above_lo && below_hi) begin
					sup_cmp = 1'b0;
				end
			end
			MODE_HYST: begin
				sup_cmp = above_hi ? 1'b1 : (below_lo ? 1'b0 : sup_r);
			end
			MODE_FALLING: begin
				sup_cmp   = (below_lo && armed_r) ? 1'b1 : (above_lo ? 1'b0 : sup_r);
				armed_cmp = above_lo ? 1'b1 : (below_lo ? 1'b0 : armed_r);
			end
			MODE_RISING: begin
				sup_cmp   = (above_hi && armed_r) ? 1'b1 : (below_hi ? 1'b0 : sup_r);
				armed_cmp = below_hi ? 1'b1 : (above_hi ? 1'b0 : armed_r);
			end
			default: begin
				sup_cmp   = 1'b0;
				armed_cmp = 1'b0;
			end
		endcase
	end

	// A start command overrides the compare in the same cycle in edge modes.
	assign start_clr = edge_mode && MOTOR_START_IN;
	assign sup_rise  = enabled && !start_clr && (state_r == SSV_CMP) && sup_cmp && !sup_r;
	assign warn_evt  = sup_rise && (action == ACT_WARN);
	assign fault_evt = sup_rise && ((action == ACT_FAULT) ||
		((action == ACT_FAULT_RUN) && MOTOR_RUNNING_IN));

	// Supervision status; the action setting is deliberately absent here.
	always_ff @(posedge CLK_SYS_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			sup_r   <= 1'b0;
			armed_r <= 1'b0;
		end else if (!enabled) begin
			sup_r   <= 1'b0;
			armed_r <= 1'b0;
		end else if (start_clr) begin
			sup_r <= 1'b0;
		end else if (state_r == SSV_CMP) begin
			sup_r   <= sup_cmp;
			armed_r <= armed_cmp;
		end
	end

	// Reactions: warning level, fault trip pulse and the last event code.
	always_ff @(posedge CLK_SYS_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			warn_r  <= 1'b0;
			fault_r <= 1'b0;
			event_r <= 16'h0000;
		end else begin
			warn_r  <= sup_r && enabled && (action == ACT_WARN);
			fault_r <= fault_evt;
			event_r <= fault_evt ? EVT_FAULT : (warn_evt ? EVT_WARN : event_r);
		end
	end

	// Sticky interrupt causes; a new event beats a write-one-to-clear in the same cycle.
	always_ff @(posedge CLK_SYS_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			irq_stat_r <= 3'h0;
		end else begin
			irq_stat_r <= (irq_stat_r & ~((do_write && aw_addr_r == ADDR_IRQ_STAT) ?
				wr_val[IRQ_W-1:0] : 3'h0)) | {fault_evt, warn_evt, sup_rise};
		end
	end

	assign SUPERV_OUT     = sup_r;
	assign WARN_OUT       = warn_r;
	assign FAULT_TRIP_OUT = fault_r;
	assign EVENT_CODE_OUT = event_r;
	assign IRQ_OUT        = |(irq_stat_r & irq_mask_r);

endmodule
`default_nettype wire
